// *** design/pea_accumulator.sv ***
/*
 * Power/energy accumulator datapath for one channel: range scaling,
 * eight-sample rolling average, signed power product, saturating
 * accumulator with adaptive low-rate scaling, refresh snapshots and an
 * AHB-Lite register slave.
 *
 * Assumes the converter delivers one signed sample pulse per
 * conversion cycle, synchronous to mclk.
 */
`timescale 1ns/10ps

module pea_accumulator #(
    parameter int AVG_DEPTH = pea_pkg::AVG_N        // Rolling average depth
) (
    input  wire logic                  mclk,
    input  wire logic                  nrst,
    // Converter side
    input  wire pea_pkg::pea_sample_t  sample,
    input  wire logic                  slowPin,
    output logic [1:0]                 permuteSel,
    output logic                       slowActive,
    output logic                       biPower,
    // AHB-Lite slave
    input  wire logic                  hsel,
    input  wire logic [7:0]            haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic                  hready,
    input  wire logic [31:0]           hwdata,
    output logic [31:0]                hrdata,
    output logic                       hreadyout,
    output logic                       hresp
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [pea_pkg::CTL_W-1:0]         ctrl_r;        // Control register
    logic                              wrPend_r;      // Write data phase due
    logic [7:0]                        wrAddr_r;      // Latched write address

    logic                              refFull;       // Clear-and-copy pulse
    logic                              refRead;       // Copy-only pulse
    logic                              slowSync_r;    // Pin level last cycle
    logic                              slowEdgeRef;   // Pin edge refresh

    logic signed [pea_pkg::RAW_W-1:0]  busHist_r  [AVG_DEPTH]; // Bus window
    logic signed [pea_pkg::RAW_W-1:0]  senseHist_r[AVG_DEPTH]; // Sense window
    logic signed [pea_pkg::RAW_W+2:0]  busSum;        // Window sums
    logic signed [pea_pkg::RAW_W+2:0]  senseSum;
    logic [3:0]                        fill_r;        // Samples since reset

    logic signed [pea_pkg::PWR_W-1:0]  power;         // Current product
    logic signed [pea_pkg::PWR_W-1:0]  power_r;       // Last product
    logic signed [pea_pkg::ACC_W-1:0]  addend;        // Scaled extended product
    logic [pea_pkg::CNT_W-1:0]         cntInc;        // Count increment
    logic signed [pea_pkg::ACC_W:0]    accSum;        // One bit of headroom
    logic signed [pea_pkg::ACC_W-1:0]  acc_r;         // Energy accumulator
    logic [pea_pkg::CNT_W-1:0]         count_r;       // Sample counter

    logic signed [pea_pkg::RAW_W-1:0]  lastBus_r;     // Latest raw results
    logic signed [pea_pkg::RAW_W-1:0]  lastSense_r;
    pea_pkg::pea_snap_t                snap_r;        // Readable snapshot
    logic [2:0]                        shiftAmt;      // Adaptive shift

    // ------------------------------------------------------------
    // Presentation function
    // ------------------------------------------------------------
    // Map a signed 17-bit result onto the 16-bit readable format.
    // Unipolar drops the sign; full bipolar drops the extra LSB.
    // Half range keeps the low 16 bits, so resolution is not lost
    // even though the range is halved.
    function automatic logic [15:0] present(
        input logic signed [pea_pkg::RAW_W-1:0] raw,
        input logic                             half,
        input logic                             bip
    );
        logic [15:0] res;
        res = raw[15:0];
        if (bip && !half)
            res = raw[16:1];
        else if (bip && half)
            res = raw[15:0];
        return res;
    endfunction : present

    // ------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------
    // Zero wait states; writes land in the data phase.
    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            wrPend_r <= 1'b0;
            wrAddr_r <= 8'h00;
        end
        else if (hready)
        begin
            wrPend_r <= hsel && htrans[1] && hwrite;
            wrAddr_r <= haddr;
        end
    end

    // Read data registered in the address phase for the data phase
    always_ff @(posedge mclk)
    begin
        if (!nrst)
            hrdata <= 32'h0000_0000;
        else if (hready && hsel && htrans[1] && !hwrite)
        begin
            case (haddr)
                pea_pkg::OFS_CTRL:    hrdata <= {24'h000000, ctrl_r};
                pea_pkg::OFS_STATUS:  hrdata <= {24'h000000, permuteSel, slowActive, biPower, fill_r};
                pea_pkg::OFS_BUSV:    hrdata <= {16'h0000, snap_r.busV};
                pea_pkg::OFS_SENSEV:  hrdata <= {16'h0000, snap_r.senseV};
                pea_pkg::OFS_BUSAVG:  hrdata <= {16'h0000, snap_r.busAvg};
                pea_pkg::OFS_SENSAVG: hrdata <= {16'h0000, snap_r.senseAvg};
                pea_pkg::OFS_POWER:   hrdata <= {2'h0, snap_r.power};
                pea_pkg::OFS_ACC_LO:  hrdata <= snap_r.acc[31:0];
                pea_pkg::OFS_ACC_HI:  hrdata <= {8'h00, snap_r.acc[55:32]};
                pea_pkg::OFS_COUNT:   hrdata <= snap_r.count;
                default:              hrdata <= 32'h0000_0000; // Unmapped reads zero
            endcase
        end
    end

    // Slave never stalls and never errors
    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;                             // Never stalls
            hresp     <= 1'b0;                             // Always OKAY
        end
    end

    // Control register; reset makes adaptive mode on, pin refresh off
    always_ff @(posedge mclk)
    begin
        if (!nrst)
            ctrl_r <= pea_pkg::CTL_RESET;
        else if (wrPend_r && wrAddr_r == pea_pkg::OFS_CTRL)
            ctrl_r <= hwdata[pea_pkg::CTL_W-1:0];
    end

    // Command decode; general call behaves as a full refresh
    assign refFull = (wrPend_r && wrAddr_r == pea_pkg::OFS_CMD
                      && (hwdata[pea_pkg::CMD_FULL] || hwdata[pea_pkg::CMD_GEN]))
                     || slowEdgeRef;
    assign refRead = wrPend_r && wrAddr_r == pea_pkg::OFS_CMD && hwdata[pea_pkg::CMD_READ];

    // ------------------------------------------------------------
    // Low-rate pin
    // ------------------------------------------------------------
    // The low-rate state takes the pin only between conversion cycles, so a
    // round robin in progress finishes at the old rate.
    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            slowSync_r <= 1'b0;
            slowActive <= 1'b0;
        end
        else
        begin
            slowSync_r <= slowPin;
            if (sample.valid)
                slowActive <= slowPin;
        end
    end

    // Optional refresh on any pin edge, off by default
    assign slowEdgeRef = ctrl_r[pea_pkg::CTL_SLOWREF] && (slowSync_r != slowPin);

    // ------------------------------------------------------------
    // Offset permutation
    // ------------------------------------------------------------
    // Step once per finished conversion
    always_ff @(posedge mclk)
    begin
        if (!nrst)
            permuteSel <= 2'h0;
        else if (sample.valid)
            permuteSel <= permuteSel + 2'h1;
    end

    // ------------------------------------------------------------
    // Rolling average
    // ------------------------------------------------------------
    // Shift window; a flat array costs area but sums in one cycle.
    genvar gi;
    generate
        for (gi = 0; gi < AVG_DEPTH; gi++)
        begin : g_hist
            localparam int PREV = (gi > 0) ? gi - 1 : 0; // Keeps slot 0 index in range
            always_ff @(posedge mclk)
            begin
                if (!nrst)
                begin
                    busHist_r[gi]   <= '0;
                    senseHist_r[gi] <= '0;
                end
                else if (sample.valid)
                begin
                    if (gi == 0)
                    begin
                        busHist_r[gi]   <= sample.busRaw;
                        senseHist_r[gi] <= sample.senseRaw;
                    end
                    else
                    begin
                        busHist_r[gi]   <= busHist_r[PREV];
                        senseHist_r[gi] <= senseHist_r[PREV];
                    end
                end
            end
        end
    endgenerate

    // Window sums; the divide is a shift
    always_comb
    begin
        busSum   = '0;
        senseSum = '0;
        for (int i = 0; i < AVG_DEPTH; i++)
        begin
            busSum   = busSum + (pea_pkg::RAW_W+3)'(busHist_r[i]);
            senseSum = senseSum + (pea_pkg::RAW_W+3)'(senseHist_r[i]);
        end
    end

    // Fill counter: averages trustworthy once eight cycles are in
    always_ff @(posedge mclk)
    begin
        if (!nrst)
            fill_r <= 4'h0;
        else if (sample.valid && fill_r < 4'(AVG_DEPTH))
            fill_r <= fill_r + 4'h1;
    end

    // ------------------------------------------------------------
    // Power product and accumulation
    // ------------------------------------------------------------
    // Sense times the top bits of bus, signed
    assign power = pea_pkg::PWR_W'($signed(sample.senseRaw)
                   * $signed(sample.busRaw[16:3]));

    // Adaptive scaling toward the top rate
    always_comb
    begin
        shiftAmt = 3'h0;
        if (ctrl_r[pea_pkg::CTL_ADAPT])
        begin
            if (slowActive)
                shiftAmt = 3'(pea_pkg::SLOW_SHIFT);
            else
            begin
                case (ctrl_r[pea_pkg::CTL_RATE_LSB +: 2])
                    pea_pkg::RATE_256: shiftAmt = 3'h2;
                    pea_pkg::RATE_64:  shiftAmt = 3'h4;
                    pea_pkg::RATE_8:   shiftAmt = 3'(pea_pkg::SLOW_SHIFT);
                    default:           shiftAmt = 3'h0;
                endcase
            end
        end
        addend = pea_pkg::ACC_W'(power) <<< shiftAmt;
        cntInc = pea_pkg::ONE_INC << shiftAmt;
        accSum = (pea_pkg::ACC_W+1)'(acc_r) + (pea_pkg::ACC_W+1)'(addend);
    end

    // One update per finished conversion; full refresh restarts
    always_ff @(posedge mclk)
    begin
        if (!nrst || refFull)
        begin
            acc_r   <= '0;
            count_r <= '0;
        end
        else if (sample.valid)
        begin
            // Overflow clamps to the signed limit
            if (accSum[pea_pkg::ACC_W] != accSum[pea_pkg::ACC_W-1])
                acc_r <= accSum[pea_pkg::ACC_W] ? {1'b1, {(pea_pkg::ACC_W-1){1'b0}}}
                                                : {1'b0, {(pea_pkg::ACC_W-1){1'b1}}};
            else
                acc_r <= accSum[pea_pkg::ACC_W-1:0];
            count_r <= count_r + cntInc;                   // Wraps silently
        end
    end

    // Latest raw results and product
    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            lastBus_r   <= '0;
            lastSense_r <= '0;
            power_r     <= '0;
        end
        else if (sample.valid)
        begin
            lastBus_r   <= sample.busRaw;
            lastSense_r <= sample.senseRaw;
            power_r     <= power;
        end
    end

    // Either signed measurement makes power and energy bipolar
    always_ff @(posedge mclk)
    begin
        if (!nrst)
            biPower <= 1'b0;
        else
            biPower <= ctrl_r[pea_pkg::CTL_BUS_BIP] || ctrl_r[pea_pkg::CTL_SNS_BIP];
    end

    // ------------------------------------------------------------
    // Snapshot on refresh
    // ------------------------------------------------------------
    // Any refresh copies the live values
    always_ff @(posedge mclk)
    begin
        if (!nrst)
            snap_r <= '0;
        else if (refFull || refRead)
        begin
            snap_r.busV     <= present(lastBus_r, ctrl_r[pea_pkg::CTL_BUS_HALF], ctrl_r[pea_pkg::CTL_BUS_BIP]);
            snap_r.senseV   <= present(lastSense_r, ctrl_r[pea_pkg::CTL_SNS_HALF], ctrl_r[pea_pkg::CTL_SNS_BIP]);
            snap_r.busAvg   <= present(pea_pkg::RAW_W'(busSum >>> pea_pkg::AVG_SH),
                                       ctrl_r[pea_pkg::CTL_BUS_HALF], ctrl_r[pea_pkg::CTL_BUS_BIP]);
            snap_r.senseAvg <= present(pea_pkg::RAW_W'(senseSum >>> pea_pkg::AVG_SH),
                                       ctrl_r[pea_pkg::CTL_SNS_HALF], ctrl_r[pea_pkg::CTL_SNS_BIP]);
            snap_r.power    <= power_r;
            snap_r.acc      <= acc_r;
            snap_r.count    <= count_r;
        end
    end

endmodule : pea_accumulator

// *** design/pea_pkg.sv ***
/*
 * Package for the power/energy accumulator datapath: register offsets,
 * reset values, field layouts, mode codes and carrier structs.
 * Assumes a single 100 MHz clock and an AHB-Lite register bus.
 */
package pea_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int RAW_W   = 17;            // Signed converter result
    localparam int RES_W   = 16;            // Readable result width
    localparam int VOP_W   = 14;            // Voltage operand of product
    localparam int PWR_W   = 30;            // Power product width
    localparam int ACC_W   = 56;            // Energy accumulator width
    localparam int CNT_W   = 32;            // Sample counter width
    localparam int AVG_N   = 8;             // Rolling average depth
    localparam int AVG_SH  = 3;             // log2 of the average depth

    // ------------------------------------------------------------
    // Scaling constants
    // ------------------------------------------------------------
    localparam int SLOW_SHIFT  = 7;         // Low-rate sample weight 2^7
    localparam logic [CNT_W-1:0] SLOW_INC = 32'h0000_0080; // 128 per sample
    localparam logic [CNT_W-1:0] ONE_INC  = 32'h0000_0001;

    // Programmed adaptive rate codes
    localparam logic [1:0] RATE_1024 = 2'h0;
    localparam logic [1:0] RATE_256  = 2'h1;
    localparam logic [1:0] RATE_64   = 2'h2;
    localparam logic [1:0] RATE_8    = 2'h3;

    // ------------------------------------------------------------
    // Register byte offsets (each register one aligned word)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL    = 8'h00; // Modes, rate, adaptive
    localparam logic [7:0] OFS_CMD     = 8'h04; // Refresh commands
    localparam logic [7:0] OFS_STATUS  = 8'h08; // Permutation, low-rate, bipolar, fill state
    localparam logic [7:0] OFS_BUSV    = 8'h0c; // Snapshot bus voltage
    localparam logic [7:0] OFS_SENSEV  = 8'h10; // Snapshot sense voltage
    localparam logic [7:0] OFS_BUSAVG  = 8'h14; // Snapshot bus average
    localparam logic [7:0] OFS_SENSAVG = 8'h18; // Snapshot sense average
    localparam logic [7:0] OFS_POWER   = 8'h1c; // Snapshot power product
    localparam logic [7:0] OFS_ACC_LO  = 8'h20; // Snapshot accumulator low
    localparam logic [7:0] OFS_ACC_HI  = 8'h24; // Snapshot accumulator high
    localparam logic [7:0] OFS_COUNT   = 8'h28; // Snapshot sample count

    // Control field positions
    localparam int CTL_BUS_HALF  = 0;       // Bus half-range
    localparam int CTL_SNS_HALF  = 1;       // Sense half-range
    localparam int CTL_BUS_BIP   = 2;       // Bus signed
    localparam int CTL_SNS_BIP   = 3;       // Sense signed
    localparam int CTL_ADAPT     = 4;       // Adaptive accumulation
    localparam int CTL_RATE_LSB  = 5;       // Programmed rate, 2 bits
    localparam int CTL_SLOWREF   = 7;       // Refresh on low-rate pin edge
    localparam int CTL_W         = 8;
    localparam logic [CTL_W-1:0] CTL_RESET = 8'h10; // Adaptive on, refresh off

    // Command bits (write one to fire)
    localparam int CMD_FULL = 0;
    localparam int CMD_READ = 1;
    localparam int CMD_GEN  = 2;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic             valid;            // Conversion finished pulse
        logic signed [RAW_W-1:0] busRaw;    // Signed bus result
        logic signed [RAW_W-1:0] senseRaw;  // Signed sense result
    } pea_sample_t;

    typedef struct packed {
        logic [RES_W-1:0] busV;
        logic [RES_W-1:0] senseV;
        logic [RES_W-1:0] busAvg;
        logic [RES_W-1:0] senseAvg;
        logic [PWR_W-1:0] power;
        logic [ACC_W-1:0] acc;
        logic [CNT_W-1:0] count;
    } pea_snap_t;

endpackage : pea_pkg

// *** testbench/pea_accumulator_sva.sv ***
/*
 * Port checker for the accumulator datapath, bound to its top module.
 * Assumes a single AHB-Lite slave whose hreadyout is the bus hready.
 */
`timescale 1ns/10ps
module pea_accumulator_sva #(
    parameter int AVG_DEPTH = 8                     // Rolling average depth
) (
    input wire logic                 mclk,
    input wire logic                 nrst,
    input wire pea_pkg::pea_sample_t sample,
    input wire logic                 slowPin,
    input wire logic [1:0]           permuteSel,
    input wire logic                 slowActive,
    input wire logic                 biPower,
    input wire logic                 hsel,
    input wire logic [7:0]           haddr,
    input wire logic [1:0]           htrans,
    input wire logic                 hwrite,
    input wire logic [2:0]           hsize,
    input wire logic                 hready,
    input wire logic [31:0]          hwdata,
    input wire logic [31:0]          hrdata,
    input wire logic                 hreadyout,
    input wire logic                 hresp
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    logic rdReq;                                    // Read address phase taken
    assign rdReq = hsel && htrans[1] && hready && !hwrite;

    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);

    // ------------------------------------------------------------
    // Converter side
    // ------------------------------------------------------------
    perm_step_a: assert property
        (sample.valid |=> permuteSel == $past(permuteSel) + 2'h1) else $error("Permutation did not step");
    perm_hold_a: assert property
        (!sample.valid |=> $stable(permuteSel)) else $error("Permutation moved without a sample");
    slow_capture_a: assert property
        (sample.valid |=> slowActive == $past(slowPin)) else $error("Low-rate state not captured");
    slow_hold_a: assert property
        (!sample.valid |=> $stable(slowActive)) else $error("Low-rate state moved between samples");

    // ------------------------------------------------------------
    // Register bus side
    // ------------------------------------------------------------
    status_view_a: assert property
        (rdReq && haddr == pea_pkg::OFS_STATUS |=> hrdata[7:4] == $past({permuteSel, slowActive, biPower}))
        else $error("Status word disagrees with live state");
    acc_top_a: assert property
        (rdReq && haddr == pea_pkg::OFS_ACC_HI |=> hrdata[31:24] == 8'h00) else $error("Accumulator top byte set");
    unmapped_zero_a: assert property
        (rdReq && haddr > pea_pkg::OFS_COUNT |=> hrdata == 32'h0) else $error("Unmapped read not zero");
    data_hold_a: assert property
        (!rdReq |=> $stable(hrdata)) else $error("Read data moved without a read");
    ready_up_a: assert property
        ($past(nrst) |-> hreadyout) else $error("Slave not ready after reset");
    resp_okay_a: assert property
        (hresp == 1'b0) else $error("Response not OKAY");
endmodule : pea_accumulator_sva

bind pea_accumulator pea_accumulator_sva #(.AVG_DEPTH(AVG_DEPTH)) chk (
    .mclk(mclk), .nrst(nrst), .sample(sample), .slowPin(slowPin), .permuteSel(permuteSel),
    .slowActive(slowActive), .biPower(biPower), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp)
);

// *** testbench/pea_converter_model.sv ***
/*
 * Converter stand-in: one signed bus/sense result pair per conversion.
 * Assumes convert is called from a single bench process.
 */
`timescale 1ns/10ps
module pea_converter_model (
    input  wire logic           mclk,
    output pea_pkg::pea_sample_t sample
);
    // Quiet lines at start
    initial
    begin
        sample = '0;
    end

    // One conversion: pulse valid, then scramble the idle result lines
    task automatic convert(input logic [16:0] busRaw, input logic [16:0] senseRaw);
        @(posedge mclk);
        sample <= {1'b1, busRaw, senseRaw};
        @(posedge mclk);
        sample <= {1'b0, ~busRaw, ~senseRaw};
        repeat (2) @(posedge mclk);
    endtask : convert
endmodule : pea_converter_model

// *** testbench/power_energy_accumulator_tb.sv ***
/*
 * Self-checking bench: AHB-Lite register tasks and converter samples.
 * Assumes the hand-over timing: zero-wait slave, one valid per sample.
 */
`timescale 1ns/10ps
module power_energy_accumulator_tb;
    // ------------------------------------------------------------
    // Signals and expectation tables
    // ------------------------------------------------------------
    logic        mclk = 1'b0;                       // 100 MHz clock
    logic        nrst, slowPin, hsel, hwrite;       // Driven by the bench
    logic        hreadyout, hresp, slowActive, biPower;
    logic [1:0]  htrans, permuteSel;
    logic [2:0]  hsize;
    logic [7:0]  haddr;
    logic [31:0] hwdata, hrdata, rd;                // rd holds the last read
    int          failures = 0, nCompared = 0, i;
    pea_pkg::pea_sample_t sample;                   // From the converter model
    logic signed [55:0] p = 56'sh1000;              // 16 times 0x800 top bits
    logic [7:0]  ctlTab [5] = '{8'h10, 8'h30, 8'h50, 8'h70, 8'h60}; // Rates, then adaptive off
    int          shTab [5] = '{0, 2, 4, 7, 0};      // Expected weight shift
    logic [7:0]  ctlPres [3] = '{8'h10, 8'h1c, 8'h1f};
    logic [15:0] expPres [3] = '{16'hfffd, 16'hfffe, 16'hfffd}; // Views of -3
    localparam logic [31:0] REFF = 32'h1 << pea_pkg::CMD_FULL;
    localparam logic [31:0] REFR = 32'h1 << pea_pkg::CMD_READ;
    localparam logic [31:0] REFG = 32'h1 << pea_pkg::CMD_GEN;

    always #5 mclk = ~mclk;

    pea_accumulator dut (
        .mclk(mclk), .nrst(nrst), .sample(sample), .slowPin(slowPin), .permuteSel(permuteSel),
        .slowActive(slowActive), .biPower(biPower), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp)
    );
    pea_converter_model conv (.mclk(mclk), .sample(sample));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic give_verdict();
        $display("Compared %0d, mismatches %0d", nCompared, failures);
        if (failures == 0 && nCompared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : give_verdict

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        nCompared++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // Bounded wait for hready; a hang ends the run
    task automatic step();
        int n;
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 50);
        if (n >= 50)
        begin
            failures++;
            $display("MISMATCH hready expected 1 seen timeout");
            give_verdict();
        end
    endtask : step

    // One single word transfer; read data lands in rd
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        step();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        step();
        rd = hrdata;
    endtask : bus

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m, input string what);
        bus(1'b0, a, 32'h0);
        check(what, exp & m, rd & m);
    endtask : rdchk

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        nrst = 1'b0;
        slowPin = 1'b0;
        hsel = 1'b0;
        htrans = 2'h0;
        haddr = 8'h00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        repeat (8) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        rdchk(pea_pkg::OFS_CTRL, 32'h10, 32'hffffffff, "control");
        rdchk(pea_pkg::OFS_STATUS, 32'h0, 32'hff, "status");
        // Outlier first, then an eight-step ramp
        conv.convert(17'h0f000, 17'h0f000);
        for (i = 0; i < 8; i++)
        begin
            conv.convert(17'(i * 16), 17'(i * 32));
            if (i == 3) rdchk(pea_pkg::OFS_STATUS, 32'h45, 32'hff, "fill");
        end
        rdchk(pea_pkg::OFS_STATUS, 32'h48, 32'hff, "fill");
        rdchk(pea_pkg::OFS_BUSAVG, 32'h0, 32'hffff, "early avg");
        bus(1'b1, pea_pkg::OFS_CMD, REFR);
        rdchk(pea_pkg::OFS_BUSAVG, 32'h38, 32'hffff, "bus avg");
        rdchk(pea_pkg::OFS_SENSAVG, 32'h70, 32'hffff, "sense avg");
        // Presentation modes on a small negative result
        for (i = 0; i < 3; i++)
        begin
            bus(1'b1, pea_pkg::OFS_CTRL, {24'h0, ctlPres[i]});
            conv.convert(17'h1fffd, 17'h1fffd);
            bus(1'b1, pea_pkg::OFS_CMD, REFR);
            rdchk(pea_pkg::OFS_BUSV, {16'h0, expPres[i]}, 32'hffff, "bus view");
            rdchk(pea_pkg::OFS_SENSEV, {16'h0, expPres[i]}, 32'hffff, "sense view");
            rdchk(pea_pkg::OFS_STATUS, {27'h0, i != 0, 4'h0}, 32'h10, "bipolar");
        end
        // Every programmed rate, then adaptive off; readings refresh keeps the sum
        for (i = 0; i < 5; i++)
        begin
            bus(1'b1, pea_pkg::OFS_CTRL, {24'h0, ctlTab[i]});
            bus(1'b1, pea_pkg::OFS_CMD, i[0] ? REFG : REFF);
            conv.convert(17'h00800, 17'h00010);
            bus(1'b1, pea_pkg::OFS_CMD, REFR);
            conv.convert(17'h00800, 17'h00010);
            bus(1'b1, pea_pkg::OFS_CMD, REFR);
            rdchk(pea_pkg::OFS_ACC_LO, 32'((p << shTab[i]) * 2), 32'hffffffff, "acc");
            rdchk(pea_pkg::OFS_COUNT, 32'(2 << shTab[i]), 32'hffffffff, "count");
            rdchk(pea_pkg::OFS_POWER, 32'h1000, 32'h3fffffff, "power");
        end
        // Low-rate pin: shifted samples; its edge must not refresh by default
        bus(1'b1, pea_pkg::OFS_CTRL, 32'h10);
        slowPin <= 1'b1;
        conv.convert(17'h00800, 17'h00010);
        bus(1'b1, pea_pkg::OFS_CMD, REFF);
        conv.convert(17'h00800, 17'h00010);
        slowPin <= 1'b0;
        repeat (4) @(posedge mclk);
        bus(1'b1, pea_pkg::OFS_CMD, REFR);
        rdchk(pea_pkg::OFS_ACC_LO, 32'h80000, 32'hffffffff, "slow acc");
        rdchk(pea_pkg::OFS_COUNT, 32'h80, 32'hffffffff, "slow count");
        // Negative power lowers the total
        conv.convert(17'h00800, 17'h00010);
        bus(1'b1, pea_pkg::OFS_CMD, REFF);
        conv.convert(17'h00800, 17'h1fff0);
        bus(1'b1, pea_pkg::OFS_CMD, REFR);
        rdchk(pea_pkg::OFS_ACC_LO, 32'hfffff000, 32'hffffffff, "neg acc");
        rdchk(pea_pkg::OFS_ACC_HI, 32'h00ffffff, 32'h00ffffff, "acc high");
        rdchk(pea_pkg::OFS_POWER, 32'h3ffff000, 32'h3fffffff, "neg power");
        rdchk(8'hfc, 32'h0, 32'hffffffff, "unmapped");
        give_verdict();
    end
endmodule : power_energy_accumulator_tb
